// ===== rtl/seebfe_defines.svh
// Constants for the serial memory bus front end
`ifndef SEEBFE_DEFINES_SVH
`define SEEBFE_DEFINES_SVH
`define SEEBFE_CLK_NS 10
`define SEEBFE_TYPE_CODE 4'hA
`define SEEBFE_WORD_BITS 4'h8
`define SEEBFE_ACK_BIT 4'h9
`define SEEBFE_WADDR_BITS 13
`define SEEBFE_PROT_QUAD 2'h3
`define SEEBFE_WRITE_US 5000
`define SEEBFE_WRITE_CYC ((`SEEBFE_WRITE_US * 1000) / `SEEBFE_CLK_NS)
`define SEEBFE_SPIKE_NS 100
`define SEEBFE_SPIKE_CYC (((`SEEBFE_SPIKE_NS + `SEEBFE_CLK_NS - 1) / `SEEBFE_CLK_NS) + 1)
`define SEEBFE_HALF_DIV 8'h40
`define SEEBFE_RECOVER_PULSES 4'h9
`endif

// ===== rtl/seebfe_pkg.sv
// Types shared by both ends of the serial memory bus
package seebfe_pkg;
    typedef enum logic [2:0] {
        SEEBFE_ST_IDLE, SEEBFE_ST_DEV, SEEBFE_ST_ADDR_HI, SEEBFE_ST_ADDR_LO, SEEBFE_ST_WDATA, SEEBFE_ST_RDATA
    } seebfe_dev_state_t;
    typedef enum logic [2:0] {
        SEEBFE_H_IDLE, SEEBFE_H_RECOVER, SEEBFE_H_START, SEEBFE_H_BITS, SEEBFE_H_STOP
    } seebfe_host_state_t;
endpackage : seebfe_pkg

// ===== rtl/seebfe_bus_if.sv
// Two-wire link between controller and memory front end
`timescale 1ns/1ns
interface seebfe_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;
    // Open drain with pull-ups: any enabled low driver wins
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
    modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe, input scl, input sda);
    modport device (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface : seebfe_bus_if

// ===== rtl/seebfe_device.sv
// Memory side of the two-wire bus: framing, addressing, protection, write timer
// How it works
// - data edges with clock high are framing
// - falling data, clock high, starts transfer
// - rising data, clock high, stops transfer
// - stop after read enters standby
// - eight-bit words, acknowledge on ninth clock
// - standby at reset and after stop, once any self-timed write has finished
// - controller clocks up to nine times, until data reads high, then starts
// - upper four address bits must match type
// - next three bits must match straps
// - unconnected strap reads low
// - last address bit selects read or write
// - match acknowledges, mismatch releases and idles
// - write protect blocks upper quadrant writes
// - self-timed write lasts five milliseconds
// - spikes shorter than filter time ignored
// - sample on rising, drive after falling
// - word address thirteen bits wide
// - two address bytes follow, each acknowledged
// - no acknowledge while write is running
`timescale 1ns/1ns
`include "seebfe_defines.svh"
module seebfe_device (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Bus
    seebfe_bus_if.device bus,
    // Straps and protection pins
    input wire logic [2:0] chip_select_strap_i,
    input wire logic write_protect_i,
    // Memory array side
    input wire logic [7:0] rd_data_i,
    output logic [12:0] word_addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_stb_o,
    output logic rd_stb_o,
    output logic rd_not_wr_o,
    output logic standby_o,
    output logic write_busy_o
);
    localparam int SPIKE_CYC = `SEEBFE_SPIKE_CYC;
    localparam int WRITE_CYC = `SEEBFE_WRITE_CYC;
    logic [1:0] scl_sync_ff, sda_sync_ff;
    logic scl_flt_ff, sda_flt_ff, scl_prev_ff, sda_prev_ff;
    logic [3:0] scl_cnt_ff, sda_cnt_ff;
    seebfe_pkg::seebfe_dev_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic ack_pend_ff, ack_drive_ff, tx_drive_ff, tx_bit_ff, master_ack_ff;
    logic [12:0] addr_ff;
    logic [7:0] wdata_ff;
    logic wr_stb_ff, rd_stb_ff, rnw_ff, standby_ff, wrote_ff;
    logic [22:0] wr_timer_ff;
    logic page_inc_ff;
    logic [1:0] wp_sync_ff;
    logic [2:0] strap_meta_ff, strap_sync_ff;
    logic scl_rise, scl_fall, start_det, stop_det, word_done, dev_match;
    // Filter: a level must hold for the spike time before it is believed
    function automatic logic [3:0] seebfe_flt_cnt(input logic raw, input logic flt, input logic [3:0] cnt);
        seebfe_flt_cnt = (raw == flt) ? 4'h0 : cnt + 4'h1;
    endfunction : seebfe_flt_cnt
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            wp_sync_ff <= 2'h0;
            strap_meta_ff <= 3'h0;
            strap_sync_ff <= 3'h0;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], bus.scl};
            sda_sync_ff <= {sda_sync_ff[0], bus.sda};
            wp_sync_ff <= {wp_sync_ff[0], write_protect_i};
            strap_meta_ff <= chip_select_strap_i;
            strap_sync_ff <= strap_meta_ff;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            scl_cnt_ff <= 4'h0;
            sda_cnt_ff <= 4'h0;
            scl_flt_ff <= 1'b1;
            sda_flt_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_cnt_ff <= seebfe_flt_cnt(scl_sync_ff[1], scl_flt_ff, scl_cnt_ff);
            sda_cnt_ff <= seebfe_flt_cnt(sda_sync_ff[1], sda_flt_ff, sda_cnt_ff);
            if (scl_cnt_ff == 4'(SPIKE_CYC)) begin
                scl_flt_ff <= scl_sync_ff[1];
                scl_cnt_ff <= 4'h0;
            end
            if (sda_cnt_ff == 4'(SPIKE_CYC)) begin
                sda_flt_ff <= sda_sync_ff[1];
                sda_cnt_ff <= 4'h0;
            end
            scl_prev_ff <= scl_flt_ff;
            sda_prev_ff <= sda_flt_ff;
        end
    end
    assign scl_rise = scl_flt_ff & ~scl_prev_ff;
    assign scl_fall = ~scl_flt_ff & scl_prev_ff;
    assign start_det = scl_flt_ff & scl_prev_ff & sda_prev_ff & ~sda_flt_ff;
    assign stop_det = scl_flt_ff & scl_prev_ff & ~sda_prev_ff & sda_flt_ff;
    assign word_done = scl_fall && bit_cnt_ff == `SEEBFE_WORD_BITS && !ack_pend_ff;
    // Floating straps rely on the pull-down outside to read low
    assign dev_match = shift_ff[7:4] == `SEEBFE_TYPE_CODE
        && shift_ff[3:1] == strap_sync_ff
        && !write_busy_o;
    // Bit counter and shifter
    always_ff @(posedge clk_i) begin
        if (!rstn_i || start_det) begin
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
        end else if (scl_rise && bit_cnt_ff < `SEEBFE_WORD_BITS) begin
            shift_ff <= {shift_ff[6:0], sda_flt_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else if (scl_rise) begin
            master_ack_ff <= ~sda_flt_ff;
            bit_cnt_ff <= `SEEBFE_ACK_BIT;
        end else if (scl_fall && bit_cnt_ff == `SEEBFE_ACK_BIT) begin
            bit_cnt_ff <= 4'h0;
        end
    end
    // Protocol state
    always_ff @(posedge clk_i) begin
        wr_stb_ff <= 1'b0;
        rd_stb_ff <= 1'b0;
        page_inc_ff <= 1'b0;
        if (!rstn_i) begin
            state_ff <= seebfe_pkg::SEEBFE_ST_IDLE;
            ack_pend_ff <= 1'b0;
            ack_drive_ff <= 1'b0;
            tx_drive_ff <= 1'b0;
            tx_bit_ff <= 1'b1;
            addr_ff <= 13'h0000;
            wdata_ff <= 8'h00;
            rnw_ff <= 1'b0;
            wrote_ff <= 1'b0;
        end else if (start_det) begin
            state_ff <= seebfe_pkg::SEEBFE_ST_DEV;
            ack_drive_ff <= 1'b0;
            tx_drive_ff <= 1'b0;
            ack_pend_ff <= 1'b0;
            wrote_ff <= 1'b0;
        end else if (stop_det) begin
            state_ff <= seebfe_pkg::SEEBFE_ST_IDLE;
            ack_drive_ff <= 1'b0;
            tx_drive_ff <= 1'b0;
        end else begin
            if (page_inc_ff) begin
                addr_ff[4:0] <= addr_ff[4:0] + 5'h01;
            end
            if (scl_fall && bit_cnt_ff == `SEEBFE_ACK_BIT) begin
                ack_drive_ff <= 1'b0;
                ack_pend_ff <= 1'b0;
                tx_drive_ff <= 1'b0;
                if (state_ff == seebfe_pkg::SEEBFE_ST_RDATA && master_ack_ff) begin
                    tx_drive_ff <= 1'b1;
                    tx_bit_ff <= rd_data_i[7];
                end else if (state_ff == seebfe_pkg::SEEBFE_ST_RDATA) begin
                    state_ff <= seebfe_pkg::SEEBFE_ST_IDLE;
                end
            end
            if (word_done) begin
                ack_pend_ff <= 1'b1;
                unique case (state_ff)
                    seebfe_pkg::SEEBFE_ST_DEV: begin
                        if (dev_match) begin
                            ack_drive_ff <= 1'b1;
                            rnw_ff <= shift_ff[0];
                            state_ff <= shift_ff[0] ? seebfe_pkg::SEEBFE_ST_RDATA : seebfe_pkg::SEEBFE_ST_ADDR_HI;
                            rd_stb_ff <= shift_ff[0];
                        end else begin
                            state_ff <= seebfe_pkg::SEEBFE_ST_IDLE;
                        end
                    end
                    seebfe_pkg::SEEBFE_ST_ADDR_HI: begin
                        ack_drive_ff <= 1'b1;
                        addr_ff[12:8] <= shift_ff[4:0];
                        state_ff <= seebfe_pkg::SEEBFE_ST_ADDR_LO;
                    end
                    seebfe_pkg::SEEBFE_ST_ADDR_LO: begin
                        ack_drive_ff <= 1'b1;
                        addr_ff[7:0] <= shift_ff;
                        state_ff <= seebfe_pkg::SEEBFE_ST_WDATA;
                    end
                    seebfe_pkg::SEEBFE_ST_WDATA: begin
                        ack_drive_ff <= 1'b1;
                        if (!(wp_sync_ff[1] && addr_ff[12:11] == `SEEBFE_PROT_QUAD)) begin
                            wdata_ff <= shift_ff;
                            wr_stb_ff <= 1'b1;
                            wrote_ff <= 1'b1;
                        end
                        // Bump after the strobe so the memory sees this word's address
                        page_inc_ff <= 1'b1;
                    end
                    seebfe_pkg::SEEBFE_ST_RDATA: begin
                        addr_ff <= addr_ff + 13'h0001;
                        rd_stb_ff <= 1'b1;
                    end
                    seebfe_pkg::SEEBFE_ST_IDLE: begin
                        ack_pend_ff <= 1'b0;
                    end
                endcase
            end
            if (scl_fall && state_ff == seebfe_pkg::SEEBFE_ST_RDATA && tx_drive_ff) begin
                // Let go only after the last bit so the controller can answer
                if (bit_cnt_ff < `SEEBFE_WORD_BITS) begin
                    tx_bit_ff <= rd_data_i[3'(7 - bit_cnt_ff)];
                end else begin
                    tx_drive_ff <= 1'b0;
                end
            end
            if (scl_fall && ack_drive_ff && bit_cnt_ff == `SEEBFE_ACK_BIT
                    && state_ff == seebfe_pkg::SEEBFE_ST_RDATA && rnw_ff && !tx_drive_ff) begin
                tx_drive_ff <= 1'b1;
                tx_bit_ff <= rd_data_i[7];
            end
        end
    end
    // Self-timed write: counts from the stop that closes a write
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_timer_ff <= 23'h000000;
        end else if (stop_det && wrote_ff && wr_timer_ff == 23'h000000) begin
            wr_timer_ff <= 23'(WRITE_CYC);
        end else if (wr_timer_ff != 23'h000000) begin
            wr_timer_ff <= wr_timer_ff - 23'h000001;
        end
    end
    assign write_busy_o = wr_timer_ff != 23'h000000;
    // Standby whenever idle and nothing internal is running
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            standby_ff <= 1'b1;
        end else begin
            standby_ff <= state_ff == seebfe_pkg::SEEBFE_ST_IDLE && !write_busy_o;
        end
    end
    // Ack drives low; read data drives only its zeros, ones float on the pull-up
    assign bus.sda_dev_oe = ack_drive_ff | (tx_drive_ff & ~tx_bit_ff);
    assign bus.sda_dev_o = 1'b0;
    assign word_addr_o = addr_ff;
    assign wr_data_o = wdata_ff;
    assign wr_stb_o = wr_stb_ff;
    assign rd_stb_o = rd_stb_ff;
    assign rd_not_wr_o = rnw_ff;
    assign standby_o = standby_ff;
endmodule : seebfe_device

// ===== rtl/seebfe_host.sv
// Controller side of the two-wire bus: recovery, start, byte, stop
`timescale 1ns/1ns
`include "seebfe_defines.svh"
module seebfe_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Bus
    seebfe_bus_if.host bus,
    // User command
    input wire logic recover_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic byte_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_ack_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rx_data_o,
    output logic ack_seen_o
);
    seebfe_pkg::seebfe_host_state_t state_ff;
    logic [7:0] div_ff;
    logic [1:0] phase_ff;
    logic [3:0] cnt_ff;
    logic [8:0] sh_ff;
    logic [7:0] rx_ff;
    logic scl_ff, sda_ff, done_ff, ack_ff;
    logic [1:0] sda_sync_ff;
    logic tick;
    assign tick = div_ff == `SEEBFE_HALF_DIV;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sda_sync_ff <= 2'h3;
        end else begin
            sda_sync_ff <= {sda_sync_ff[0], bus.sda};
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i || state_ff == seebfe_pkg::SEEBFE_H_IDLE || tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        done_ff <= 1'b0;
        if (!rstn_i) begin
            state_ff <= seebfe_pkg::SEEBFE_H_IDLE;
            phase_ff <= 2'h0;
            cnt_ff <= 4'h0;
            sh_ff <= 9'h1FF;
            rx_ff <= 8'h00;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            ack_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                seebfe_pkg::SEEBFE_H_IDLE: begin
                    phase_ff <= 2'h0;
                    cnt_ff <= 4'h0;
                    if (recover_i) begin
                        sda_ff <= 1'b1;
                        state_ff <= seebfe_pkg::SEEBFE_H_RECOVER;
                    end else if (start_i) begin
                        state_ff <= seebfe_pkg::SEEBFE_H_START;
                    end else if (stop_i) begin
                        state_ff <= seebfe_pkg::SEEBFE_H_STOP;
                    end else if (byte_i) begin
                        sh_ff <= {tx_data_i, tx_ack_i};
                        state_ff <= seebfe_pkg::SEEBFE_H_BITS;
                    end
                end
                seebfe_pkg::SEEBFE_H_RECOVER: if (tick) begin
                    // Up to nine pulses; leaves once data reads high with clock high
                    if (scl_ff && (sda_sync_ff[1] || cnt_ff == `SEEBFE_RECOVER_PULSES)) begin
                        state_ff <= seebfe_pkg::SEEBFE_H_START;
                    end else begin
                        scl_ff <= ~scl_ff;
                        cnt_ff <= cnt_ff + {3'h0, scl_ff};
                    end
                end
                seebfe_pkg::SEEBFE_H_START: if (tick) begin
                    phase_ff <= phase_ff + 2'h1;
                    unique case (phase_ff)
                        // Data rises before the clock so a repeated start is no stop
                        2'h0: sda_ff <= 1'b1;
                        2'h1: scl_ff <= 1'b1;
                        2'h2: sda_ff <= 1'b0;
                        default: begin
                            scl_ff <= 1'b0;
                            done_ff <= 1'b1;
                            state_ff <= seebfe_pkg::SEEBFE_H_IDLE;
                        end
                    endcase
                end
                seebfe_pkg::SEEBFE_H_BITS: if (tick) begin
                    phase_ff <= phase_ff + 2'h1;
                    unique case (phase_ff)
                        2'h0: sda_ff <= sh_ff[8]; // data moves with clock low
                        2'h1: scl_ff <= 1'b1;
                        2'h2: begin
                            if (cnt_ff < `SEEBFE_WORD_BITS) begin
                                rx_ff <= {rx_ff[6:0], sda_sync_ff[1]};
                            end else begin
                                ack_ff <= ~sda_sync_ff[1];
                            end
                        end
                        default: begin
                            scl_ff <= 1'b0;
                            sh_ff <= {sh_ff[7:0], 1'b1};
                            cnt_ff <= cnt_ff + 4'h1;
                            if (cnt_ff == `SEEBFE_WORD_BITS) begin
                                sda_ff <= 1'b1;
                                done_ff <= 1'b1;
                                state_ff <= seebfe_pkg::SEEBFE_H_IDLE;
                            end
                        end
                    endcase
                end
                seebfe_pkg::SEEBFE_H_STOP: if (tick) begin
                    phase_ff <= phase_ff + 2'h1;
                    unique case (phase_ff)
                        2'h0: sda_ff <= 1'b0;
                        2'h1: scl_ff <= 1'b1;
                        2'h2: begin
                            sda_ff <= 1'b1;
                            done_ff <= 1'b1;
                            state_ff <= seebfe_pkg::SEEBFE_H_IDLE;
                        end
                        default: state_ff <= seebfe_pkg::SEEBFE_H_IDLE;
                    endcase
                end
                default: state_ff <= seebfe_pkg::SEEBFE_H_IDLE;
            endcase
        end
    end
    // Open drain: drive only lows
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = ~scl_ff;
    assign bus.sda_host_o = 1'b0;
    assign bus.sda_host_oe = ~sda_ff;
    assign busy_o = state_ff != seebfe_pkg::SEEBFE_H_IDLE;
    assign done_o = done_ff;
    assign rx_data_o = rx_ff;
    assign ack_seen_o = ack_ff;
endmodule : seebfe_host

// ===== testbench/seebfe_bus_assertions.sv
// Wire-level checks for the two-wire memory bus
`timescale 1ns/1ns
module seebfe_bus_assertions (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Resolved lines and drive enables
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_host_oe,
    input wire logic sda_dev_oe
);
    logic scl_ff;
    logic sda_ff;
    logic [3:0] bit_cnt_ff;
    logic [3:0] word_cnt_ff;
    logic rw_ff;
    logic framed_ff;
    logic [3:0] hi_cnt_ff;
    logic start_w;
    logic stop_w;
    logic rise_w;
    assign start_w = scl & scl_ff & sda_ff & ~sda;
    assign stop_w = scl & scl_ff & ~sda_ff & sda;
    assign rise_w = scl & ~scl_ff;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_ff <= scl;
            sda_ff <= sda;
        end
    end
    // Bit position within the current nine-clock word
    always_ff @(posedge clk_i) begin
        if (!rstn_i || start_w || stop_w) begin
            bit_cnt_ff <= 4'h0;
        end else if (rise_w) begin
            bit_cnt_ff <= (bit_cnt_ff == 4'h9) ? 4'h1 : bit_cnt_ff + 4'h1;
        end
    end
    // Saturates so long page transfers never look like a fresh address word
    always_ff @(posedge clk_i) begin
        if (!rstn_i || start_w || stop_w) begin
            word_cnt_ff <= 4'h0;
        end else if (rise_w && bit_cnt_ff == 4'h9 && word_cnt_ff != 4'hF) begin
            word_cnt_ff <= word_cnt_ff + 4'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i || start_w) begin
            rw_ff <= 1'b0;
        end else if (rise_w && bit_cnt_ff == 4'h7 && word_cnt_ff == 4'h0) begin
            rw_ff <= sda;
        end
    end
    // Recovery clocking happens outside any frame
    always_ff @(posedge clk_i) begin
        if (!rstn_i || stop_w) begin
            framed_ff <= 1'b0;
        end else if (start_w) begin
            framed_ff <= 1'b1;
        end
    end
    // Cycles the clock has stood high, saturating
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !scl) begin
            hi_cnt_ff <= 4'h0;
        end else if (hi_cnt_ff != 4'hF) begin
            hi_cnt_ff <= hi_cnt_ff + 4'h1;
        end
    end
    AST_DEV_SDA_SCL_LOW: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("device data drive changed while clock high");
    AST_RESET_RELEASED: assert property ($rose(rstn_i) |-> !sda_dev_oe && !sda_host_oe)
        else $error("data line driven right after reset");
    AST_ACK_AFTER_EIGHT: assert property ($rose(sda_dev_oe) && !rw_ff |-> bit_cnt_ff == 4'h8)
        else $error("device drive began away from the ninth bit");
    AST_QUIET_BEFORE_ADDR: assert property (word_cnt_ff == 4'h0 && bit_cnt_ff < 4'h8 |-> !sda_dev_oe)
        else $error("device drove during the address word");
    AST_ACK_HELD: assert property (rise_w && bit_cnt_ff == 4'h8 && sda_dev_oe |-> sda_dev_oe [*8])
        else $error("acknowledge dropped while clock high");
    AST_ACK_DROPS: assert property ($fell(scl) && bit_cnt_ff == 4'h9 && !rw_ff && sda_dev_oe
        |-> ##[1:20] !sda_dev_oe)
        else $error("acknowledge not released after ninth clock");
    AST_QUIET_AFTER_STOP: assert property (stop_w |=> !sda_dev_oe [*8])
        else $error("device drove after stop");
    AST_HOST_FRAMING: assert property ($changed(sda_host_oe) && scl && $past(scl)
        |-> hi_cnt_ff >= 4'h8 && (!framed_ff || bit_cnt_ff == 4'h1))
        else $error("controller data changed with clock high mid word");
    COV_START: cover property (start_w);
    COV_STOP: cover property (stop_w);
    COV_ACK: cover property ($rose(sda_dev_oe) && bit_cnt_ff == 4'h8);
    COV_READ_DRIVE: cover property ($rose(sda_dev_oe) && rw_ff);
endmodule : seebfe_bus_assertions

// ===== testbench/testbench.sv
// Self-checking bench joining controller and memory front end
`timescale 1ns/1ns
module testbench;
    logic clk_i;
    logic rstn_i;
    logic recover_i;
    logic start_i;
    logic stop_i;
    logic byte_i;
    logic [7:0] tx_data_i;
    logic tx_ack_i;
    logic busy_o;
    logic done_o;
    logic [7:0] rx_data_o;
    logic ack_seen_o;
    logic write_protect_i;
    logic [12:0] word_addr_o;
    logic [7:0] wr_data_o;
    logic wr_stb_o;
    logic rd_not_wr_o;
    logic standby_o;
    logic write_busy_o;
    logic standby_b_o;
    logic [12:0] wr_addr_q;
    logic [7:0] wr_data_q;
    int wr_cnt;
    int mismatches;
    int check_count;
    seebfe_bus_if u_seebfe_bus_if ();
    seebfe_bus_if u_seebfe_bus_if_b ();
    seebfe_host u_seebfe_host (.clk_i(clk_i), .rstn_i(rstn_i), .bus(u_seebfe_bus_if.host), .recover_i(recover_i),
        .start_i(start_i), .stop_i(stop_i), .byte_i(byte_i), .tx_data_i(tx_data_i), .tx_ack_i(tx_ack_i),
        .busy_o(busy_o), .done_o(done_o), .rx_data_o(rx_data_o), .ack_seen_o(ack_seen_o));
    seebfe_device u_seebfe_device (.clk_i(clk_i), .rstn_i(rstn_i), .bus(u_seebfe_bus_if.device),
        .chip_select_strap_i(3'h5), .write_protect_i(write_protect_i), .rd_data_i(8'h96), .word_addr_o(word_addr_o),
        .wr_data_o(wr_data_o), .wr_stb_o(wr_stb_o), .rd_stb_o(), .rd_not_wr_o(rd_not_wr_o), .standby_o(standby_o),
        .write_busy_o(write_busy_o));
    // Second end driven by hand to inject spikes
    seebfe_device u_seebfe_device_b (.clk_i(clk_i), .rstn_i(rstn_i), .bus(u_seebfe_bus_if_b.device),
        .chip_select_strap_i(3'h5), .write_protect_i(1'b0), .rd_data_i(8'h00), .word_addr_o(), .wr_data_o(),
        .wr_stb_o(), .rd_stb_o(), .rd_not_wr_o(), .standby_o(standby_b_o), .write_busy_o());
    seebfe_bus_assertions u_seebfe_bus_assertions (.clk_i(clk_i), .rstn_i(rstn_i), .scl(u_seebfe_bus_if.scl),
        .sda(u_seebfe_bus_if.sda), .sda_host_oe(u_seebfe_bus_if.sda_host_oe),
        .sda_dev_oe(u_seebfe_bus_if.sda_dev_oe));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        if (wr_stb_o === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_addr_q <= word_addr_o;
            wr_data_q <= wr_data_o;
        end
    end
    task check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    // One command: recover, start, stop or byte, one-hot in that order
    task cmd(input logic [3:0] kind, input logic [7:0] data);
        int i;
        @(negedge clk_i);
        {recover_i, start_i, stop_i, byte_i} = kind;
        tx_data_i = data;
        @(negedge clk_i);
        {recover_i, start_i, stop_i, byte_i} = 4'h0;
        for (i = 0; i < 4000 && done_o !== 1'b1; i++) @(negedge clk_i);
        if (done_o !== 1'b1) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, done_o, 1'b1);
            results();
        end
    endtask : cmd
    // Sends a byte with the ninth bit released and compares the acknowledge
    task wbyte(input logic [7:0] data, input logic exp_ack);
        cmd(4'h1, data);
        check({15'h0, ack_seen_o}, {15'h0, exp_ack});
    endtask : wbyte
    initial begin
        rstn_i = 1'b0;
        {recover_i, start_i, stop_i, byte_i} = 4'h0;
        tx_data_i = 8'h00;
        tx_ack_i = 1'b1;
        write_protect_i = 1'b0;
        wr_cnt = 0;
        mismatches = 0;
        check_count = 0;
        u_seebfe_bus_if_b.scl_o = 1'b0;
        u_seebfe_bus_if_b.scl_oe = 1'b0;
        u_seebfe_bus_if_b.sda_host_o = 1'b0;
        u_seebfe_bus_if_b.sda_host_oe = 1'b0;
        repeat (16) @(negedge clk_i);
        rstn_i = 1'b1;
        @(negedge clk_i);
        check({15'h0, standby_o}, 16'h0001);
        check({15'h0, write_busy_o}, 16'h0000);
        // Spike of 50 ns on data with clock high is not a start
        u_seebfe_bus_if_b.sda_host_oe = 1'b1;
        repeat (5) @(negedge clk_i);
        u_seebfe_bus_if_b.sda_host_oe = 1'b0;
        repeat (40) @(negedge clk_i);
        check({15'h0, standby_b_o}, 16'h0001);
        u_seebfe_bus_if_b.sda_host_oe = 1'b1;
        repeat (40) @(negedge clk_i);
        check({15'h0, standby_b_o}, 16'h0000);
        u_seebfe_bus_if_b.sda_host_oe = 1'b0;
        repeat (40) @(negedge clk_i);
        check({15'h0, standby_b_o}, 16'h0001);
        cmd(4'h8, 8'h00);
        check({15'h0, u_seebfe_bus_if.sda}, 16'h0000);
        // Wrong type nibble, then wrong strap bits
        cmd(4'h4, 8'h00);
        wbyte(8'hBA, 1'b0);
        cmd(4'h2, 8'h00);
        check({15'h0, standby_o}, 16'h0001);
        cmd(4'h4, 8'h00);
        wbyte(8'hA0, 1'b0);
        cmd(4'h2, 8'h00);
        // Current address read, controller answers with no acknowledge
        cmd(4'h4, 8'h00);
        wbyte(8'hAB, 1'b1);
        wbyte(8'hFF, 1'b0);
        check({8'h00, rx_data_o}, 16'h0096);
        check({15'h0, rd_not_wr_o}, 16'h0001);
        cmd(4'h2, 8'h00);
        repeat (50) @(negedge clk_i);
        check({15'h0, standby_o}, 16'h0001);
        // Protected quadrant write is acknowledged but blocked
        write_protect_i = 1'b1;
        cmd(4'h4, 8'h00);
        wbyte(8'hAA, 1'b1);
        wbyte(8'h18, 1'b1);
        wbyte(8'h00, 1'b1);
        wbyte(8'h11, 1'b1);
        check(16'(wr_cnt), 16'h0000);
        // Repeated start, last address below the quadrant still writes
        cmd(4'h4, 8'h00);
        wbyte(8'hAA, 1'b1);
        wbyte(8'h17, 1'b1);
        wbyte(8'hFF, 1'b1);
        wbyte(8'h22, 1'b1);
        check(16'(wr_cnt), 16'h0001);
        check({3'h0, wr_addr_q}, 16'h17FF);
        check({8'h00, wr_data_q}, 16'h0022);
        check({15'h0, rd_not_wr_o}, 16'h0000);
        cmd(4'h2, 8'h00);
        repeat (50) @(negedge clk_i);
        check({15'h0, write_busy_o}, 16'h0001);
        check({15'h0, standby_o}, 16'h0000);
        // Polling during the self-timed write is refused
        cmd(4'h4, 8'h00);
        wbyte(8'hAA, 1'b0);
        cmd(4'h2, 8'h00);
        check({15'h0, write_busy_o}, 16'h0001);
        results();
    end
endmodule : testbench
